// ---- hdl/tx_bond_pkg.sv ----
// Summary of operation
// R1 - Dual bonding pairs A with B, C with D
// R2 - Dual: A type from A control pair
// R3 - Dual: B type from B high, A low
// R4 - Dual: B low set starts sync on A, B
// R5 - Dual: C type from C control pair
// R6 - Dual: D type from D high, C low
// R7 - Dual: D low set starts sync on C, D
// R8 - Quad bonding ignores C and D low bits
// R9 - Quad: each type from own high, A low
// R10 - Quad: B low set starts sync on all
// R11 - Shared character select never affects characters
// R12 - Host drives low enable bits for self test
// R13 - Self test channel ignores its parallel inputs
// R14 - Loopback forces enabled drivers to logic one
// R15 - Open enable latch passes high enables through
// R16 - Open enable latch low input disables driver
// R17 - Both drivers off powers channel logic down
// R18 - Closing enable latch holds all eight bits
// R19 - Device reset clears enable latch, drivers off
// R20 - Host presents control and byte together
// R21 - All bonded channels decode in one cycle
`default_nettype none
package tx_bond_pkg;

    // ------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------
    localparam int unsigned      ADDR_W          = 12;
    localparam logic [11:0]      CTRL_OFFSET     = 12'h000;  // Control register.
    localparam logic [11:0]      STATUS_OFFSET   = 12'h004;  // Status register.
    localparam int unsigned      CTRL_BOND_LSB   = 0;        // Bonding select, two bits.
    localparam int unsigned      CTRL_LOOP_BIT   = 2;        // Local loopback enable.
    localparam int unsigned      CTRL_OUTPUT_ENABLE_LATCH_EN_BIT   = 3;        // Output enable latch enable.
    localparam int unsigned      CTRL_SELFTEST_LATCH_EN_BIT = 4;        // Self test latch enable.
    localparam int unsigned      CTRL_BITS_LSB   = 8;        // Driver enable bits, eight.
    localparam int unsigned      STAT_OE_LSB     = 0;        // Output enable latch.
    localparam int unsigned      STAT_BIST_LSB   = 8;        // Self test enable latch.
    localparam int unsigned      STAT_PWR_LSB    = 16;       // Channel power flags.

    // ------------------------------------------------------------
    // Mode codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0]       BOND_DUAL       = 2'h1;     // Middle level of the selector.
    localparam logic [1:0]       BOND_QUAD       = 2'h2;     // High level; 3 also counts as high.
    localparam logic [7:0]       OE_LATCH_RST    = 8'h00;    // All drivers disabled.
    localparam logic [7:0]       BIST_LATCH_RST  = 8'hFF;    // Self test disabled everywhere.

    // Character types; the first four equal the two-bit control code.
    typedef enum logic [2:0] {CT_DATA, CT_FILL, CT_SPECIAL, CT_WSYNC, CT_BIST} char_type_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [11:0]       paddr;
        logic [31:0]       pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic              valid;              // One character per channel this cycle.
        logic [3:0][1:0]   charCtlPerChannel;  // Index 0 is channel A.
        logic [3:0][7:0]   txParallelByte;
    } char_in_t;

    typedef struct packed {
        logic              strobe;
        char_type_t [3:0]  charType;
        logic [3:0][7:0]   charByte;
        logic [3:0][3:0]   syncIndex;          // Position inside a word sync sequence.
    } char_out_t;

    typedef struct packed {
        logic [1:0]        rxBondingSelect;
        logic              localLoopbackEn;
        logic              outputEnableLatchEn;
        logic              selftestLatchEn;
        logic [7:0]        driverEnableBits;
    } ctrl_t;

    typedef struct packed {
        ctrl_t             ctrl;
        logic [7:0]        oeLatch;
        logic [7:0]        bistLatch;
        logic [3:0][3:0]   syncCnt;
        char_out_t         out;
        logic [7:0]        driverOne;
        logic [3:0]        chanPower;
        apb_rsp_t          rsp;
    } state_t;

    localparam state_t STATE_RST = '{bistLatch: BIST_LATCH_RST, oeLatch: OE_LATCH_RST, default: '0};

endpackage
`default_nettype wire

// ---- hdl/tx_bonded_char_select.sv ----
`timescale 1ns/1ns
`default_nettype none
module tx_bonded_char_select
(
    // Clock, reset and clock enable
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic                   ce,
    // Register bus
    input  wire tx_bond_pkg::apb_req_t  apbReq,
    output var  tx_bond_pkg::apb_rsp_t  apbRsp,
    // Characters from host logic
    input  wire tx_bond_pkg::char_in_t  charIn,
    // Decoded characters toward the encoders
    output var  tx_bond_pkg::char_out_t charOut,
    // Serial driver control
    output var  logic [7:0]             driverEnable,
    output var  logic [7:0]             serialDriverOne,
    output var  logic [3:0]             channelPowered
);
    import tx_bond_pkg::*;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------

    // Returns the character type of one channel from one sampled set of
    // control pairs. The shared character select is never an input here.
    function automatic char_type_t decodeType(input logic [3:0][1:0] ctl,
                                              input logic [1:0]      bond,
                                              input int unsigned     ch);
        logic [1:0]  pick;
        int unsigned grp;
        grp  = ch & 2;
        pick = ctl[ch];                                           // Unbonded mapping.
        if (bond == BOND_DUAL)                                    // R1
        begin
            if (ctl[grp + 1][0])
                pick = 2'h3;                                      // R4 R7
            else
                pick = {ctl[ch][1], ctl[grp][0]};                 // R2 R3 R5 R6
        end
        else if (bond >= BOND_QUAD)
        begin
            // Low bits of C and D take no part in this branch.
            if (ctl[1][0])
                pick = 2'h3;                                      // R10
            else
                pick = {ctl[ch][1], ctl[0][0]};                   // R8 R9
        end
        return char_type_t'({1'b0, pick});                        // R11
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    state_t     st;           // Every flip-flop of the block.
    state_t     nx;           // Next value of the whole state.
    logic       setupSeen;    // Access phase waiting for its answer.
    logic       finishing;    // Access phase completing at this edge.
    logic       addrCtrl;     // Address hits the control register.
    logic       addrStat;     // Address hits the status register.
    ctrl_t      ctrlWr;       // Control value carried by a write.

    assign setupSeen = apbReq.psel && apbReq.penable && !st.rsp.pready;
    assign finishing = apbReq.psel && apbReq.penable && st.rsp.pready;
    assign addrCtrl  = apbReq.paddr == CTRL_OFFSET;
    assign addrStat  = apbReq.paddr == STATUS_OFFSET;
    assign ctrlWr    = '{rxBondingSelect:     apbReq.pwdata[CTRL_BOND_LSB +: 2],
                         localLoopbackEn:     apbReq.pwdata[CTRL_LOOP_BIT],
                         outputEnableLatchEn: apbReq.pwdata[CTRL_OUTPUT_ENABLE_LATCH_EN_BIT],
                         selftestLatchEn:     apbReq.pwdata[CTRL_SELFTEST_LATCH_EN_BIT],
                         driverEnableBits:    apbReq.pwdata[CTRL_BITS_LSB +: 8]};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    // All next values are worked out here; the process below only stores them.
    always_comb
    begin
        nx = st;

        // The slave answers one cycle into the access phase, so pready is a
        // one-cycle pulse and the data it carries comes from a flip-flop.
        nx.rsp.pready  = setupSeen;
        nx.rsp.pslverr = setupSeen && !(addrCtrl || addrStat);
        if (setupSeen)
        begin
            nx.rsp.prdata = 32'h0000_0000;
            if (addrCtrl)
            begin
                nx.rsp.prdata[CTRL_BOND_LSB +: 2]  = st.ctrl.rxBondingSelect;
                nx.rsp.prdata[CTRL_LOOP_BIT]       = st.ctrl.localLoopbackEn;
                nx.rsp.prdata[CTRL_OUTPUT_ENABLE_LATCH_EN_BIT]       = st.ctrl.outputEnableLatchEn;
                nx.rsp.prdata[CTRL_SELFTEST_LATCH_EN_BIT]     = st.ctrl.selftestLatchEn;
                nx.rsp.prdata[CTRL_BITS_LSB +: 8]  = st.ctrl.driverEnableBits;
            end
            else if (addrStat)
            begin
                nx.rsp.prdata[STAT_OE_LSB +: 8]    = st.oeLatch;
                nx.rsp.prdata[STAT_BIST_LSB +: 8]  = st.bistLatch;
                nx.rsp.prdata[STAT_PWR_LSB +: 4]   = st.chanPower;
            end
        end

        // A write lands only at the edge that completes the access.
        if (finishing && apbReq.pwrite && addrCtrl)
            nx.ctrl = ctrlWr;

        // Both latches are open while their enable is high, and a write that
        // drops the enable still captures the bits written with it, which is
        // the value present on the falling transition.
        if (st.ctrl.outputEnableLatchEn || nx.ctrl.outputEnableLatchEn)
            nx.oeLatch = nx.ctrl.driverEnableBits;                // R15 R16 R18
        if (st.ctrl.selftestLatchEn || nx.ctrl.selftestLatchEn)
            nx.bistLatch = nx.ctrl.driverEnableBits;              // R12

        // Every channel decodes from the same sampled control set.
        nx.out.strobe = charIn.valid;                             // R21
        if (charIn.valid)
        begin
            for (int unsigned ch = 0; ch < 4; ch++)
            begin
                if (!st.bistLatch[2 * ch + 1])
                begin
                    // Self test owns the channel; its inputs are dropped.
                    nx.out.charType[ch]  = CT_BIST;               // R13
                    nx.out.charByte[ch]  = 8'h00;
                    nx.out.syncIndex[ch] = 4'h0;
                    nx.syncCnt[ch]       = 4'h0;
                end
                else if (st.syncCnt[ch] != 4'h0)
                begin
                    // A started sequence runs its sixteen characters out.
                    nx.out.charType[ch]  = CT_WSYNC;
                    nx.out.charByte[ch]  = charIn.txParallelByte[ch];
                    nx.out.syncIndex[ch] = st.syncCnt[ch];
                    nx.syncCnt[ch]       = st.syncCnt[ch] + 4'h1;
                end
                else
                begin
                    nx.out.charType[ch]  = decodeType(charIn.charCtlPerChannel,
                                                      st.ctrl.rxBondingSelect, ch);
                    nx.out.charByte[ch]  = charIn.txParallelByte[ch];
                    nx.out.syncIndex[ch] = 4'h0;
                    nx.syncCnt[ch]       = (nx.out.charType[ch] == CT_WSYNC) ? 4'h1 : 4'h0;
                end
            end
        end

        // Driver outputs follow the latch; loopback drives a steady one.
        nx.driverOne = nx.ctrl.localLoopbackEn ? nx.oeLatch : 8'h00;  // R14
        for (int unsigned ch = 0; ch < 4; ch++)
            nx.chanPower[ch] = nx.oeLatch[2 * ch] || nx.oeLatch[2 * ch + 1];  // R17
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------

    // The reset clears the output enable latch and opens no self test.
    // A low clock enable freezes the block, the bus slave included.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            st <= STATE_RST;                                      // R19
        else if (ce)
            st <= nx;
    end

    assign apbRsp          = st.rsp;
    assign charOut         = st.out;
    assign driverEnable    = st.oeLatch;
    assign serialDriverOne = st.driverOne;
    assign channelPowered  = st.chanPower;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    logic decA;   // Channel A free to decode this cycle.
    logic decC;   // Channel C free to decode this cycle.
    logic decD;   // Channel D free to decode this cycle.
    logic ctlWr;  // Control register written at this edge.
    assign decA  = ce && charIn.valid && st.bistLatch[1] && st.syncCnt[0] == 4'h0;
    assign decC  = ce && charIn.valid && st.bistLatch[5] && st.syncCnt[2] == 4'h0;
    assign decD  = ce && charIn.valid && st.bistLatch[7] && st.syncCnt[3] == 4'h0;
    assign ctlWr = finishing && apbReq.pwrite && addrCtrl;

    a_dual_a_map: assert property (decA && st.ctrl.rxBondingSelect == BOND_DUAL  // R2
        && !charIn.charCtlPerChannel[1][0]
        |=> st.out.charType[0] == char_type_t'({1'b0, $past(charIn.charCtlPerChannel[0])}))
        else $error("Dual mode channel A type is wrong.");
    a_dual_b_map: assert property (ce && charIn.valid && st.bistLatch[3]  // R3
        && st.syncCnt[1] == 4'h0 && st.ctrl.rxBondingSelect == BOND_DUAL
        && !charIn.charCtlPerChannel[1][0]
        |=> st.out.charType[1] == char_type_t'({1'b0, $past(charIn.charCtlPerChannel[1][1]),
                                                $past(charIn.charCtlPerChannel[0][0])}))
        else $error("Dual mode channel B type is wrong.");
    a_dual_ab_sync: assert property (decA && st.ctrl.rxBondingSelect == BOND_DUAL  // R4
        && charIn.charCtlPerChannel[1][0] |=> st.out.charType[0] == CT_WSYNC
        ##0 st.syncCnt[0] == 4'h1)
        else $error("Dual mode A and B sync did not start.");
    a_dual_c_map: assert property (decC && st.ctrl.rxBondingSelect == BOND_DUAL  // R5
        && !charIn.charCtlPerChannel[3][0]
        |=> st.out.charType[2] == char_type_t'({1'b0, $past(charIn.charCtlPerChannel[2])}))
        else $error("Dual mode channel C type is wrong.");
    a_dual_d_map: assert property (decD && st.ctrl.rxBondingSelect == BOND_DUAL  // R6
        && !charIn.charCtlPerChannel[3][0]
        |=> st.out.charType[3] == char_type_t'({1'b0, $past(charIn.charCtlPerChannel[3][1]),
                                                $past(charIn.charCtlPerChannel[2][0])}))
        else $error("Dual mode channel D type is wrong.");
    a_dual_cd_sync: assert property (decC && st.ctrl.rxBondingSelect == BOND_DUAL  // R7
        && charIn.charCtlPerChannel[3][0] |=> st.out.charType[2] == CT_WSYNC)
        else $error("Dual mode C and D sync did not start.");
    a_quad_d_map: assert property (decD && st.ctrl.rxBondingSelect >= BOND_QUAD  // R9
        && !charIn.charCtlPerChannel[1][0]
        |=> st.out.charType[3] == char_type_t'({1'b0, $past(charIn.charCtlPerChannel[3][1]),
                                                $past(charIn.charCtlPerChannel[0][0])}))
        else $error("Quad mode channel D type is wrong.");
    a_quad_all_sync: assert property (decD && st.ctrl.rxBondingSelect >= BOND_QUAD  // R10
        && charIn.charCtlPerChannel[1][0] |=> st.out.charType[3] == CT_WSYNC)
        else $error("Quad mode sync did not reach channel D.");
    a_bist_masks: assert property (ce && charIn.valid && !st.bistLatch[1]  // R13
        |=> st.out.charType[0] == CT_BIST && st.out.charByte[0] == 8'h00)
        else $error("Self test channel took host input.");
    a_loop_one: assert property (serialDriverOne == (st.ctrl.localLoopbackEn ? driverEnable : 8'h00))  // R14
        else $error("Loopback level does not match enabled drivers.");
    a_oe_follow: assert property (ce && st.ctrl.outputEnableLatchEn && !ctlWr  // R15
        |=> driverEnable == $past(st.ctrl.driverEnableBits))
        else $error("Open latch did not pass enables.");
    a_oe_hold: assert property (ce && !st.ctrl.outputEnableLatchEn && !ctlWr |=> $stable(driverEnable))  // R18
        else $error("Closed latch changed.");
    a_power_pair: assert property (channelPowered[1] == (driverEnable[2] || driverEnable[3]))  // R17
        else $error("Channel B power does not follow its drivers.");

endmodule
`default_nettype wire

// ---- bench/char_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module char_host_model
(
    // Clock
    input  wire logic                   clk,
    // Characters toward the block
    output var  tx_bond_pkg::char_in_t  charIn
);
    import tx_bond_pkg::*;

    // Nothing is offered at time zero.
    initial charIn = '0;

    // Offers one character set; control pairs and bytes change together on one edge.
    task automatic send(input logic [3:0][1:0] ctl, input logic [3:0][7:0] bytes);
        charIn <= '{valid: 1'h1, charCtlPerChannel: ctl, txParallelByte: bytes};
        @(posedge clk);
    endtask

    // Drops valid; released lines show the inverse of the last values so stale data never looks good.
    task automatic release_lines();
        charIn <= '{valid: 1'h0, charCtlPerChannel: ~charIn.charCtlPerChannel,
                    txParallelByte: ~charIn.txParallelByte};
    endtask
endmodule
`default_nettype wire

// ---- bench/tx_bonded_char_select_and_driver_enable_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tx_bonded_char_select_and_driver_enable_tb_top;
    import tx_bond_pkg::*;

    // ------------------------------------------------------------
    // Signals and reference model state
    // ------------------------------------------------------------
    logic        clk;              // 100 MHz clock.
    logic        rstn;             // Asynchronous active-low reset.
    logic        ce;               // Clock enable, dropped once to freeze the block.
    apb_req_t    apbReq;           // Register bus request.
    apb_rsp_t    apbRsp;           // Register bus response.
    char_in_t    charIn;           // Characters from the host model.
    char_out_t   charOut;          // Decoded characters.
    logic [7:0]  driverEnable;     // Serial driver enables.
    logic [7:0]  serialDriverOne;  // Loopback logic-one drive.
    logic [3:0]  channelPowered;   // Channel power flags.
    int          errors;           // Mismatches seen.
    int          nTests;           // Comparisons made.
    char_out_t   expQ[$];          // Expected character sets, oldest first.
    char_out_t   monE;             // Note taken off the queue by the monitor.
    logic [7:0]  oeExp;            // Expected output enable latch.
    logic [7:0]  bistExp;          // Expected self-test latch.
    logic        oeOpen;           // Output enable latch is transparent.
    logic        bistOpen;         // Self-test latch is transparent.
    logic [1:0]  bondNow;          // Bonding level last written.
    int          syncLeft[4];      // Word sync characters still owed per channel.
    logic [31:0] rd;               // Read data of the last transfer.
    logic        er;               // Error flag of the last transfer.

    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // The clock enable stays high while characters flow, since a frozen strobe would repeat.
    tx_bonded_char_select uut
    (
        .clk             (clk),
        .rstn            (rstn),
        .ce              (ce),
        .apbReq          (apbReq),
        .apbRsp          (apbRsp),
        .charIn          (charIn),
        .charOut         (charOut),
        .driverEnable    (driverEnable),
        .serialDriverOne (serialDriverOne),
        .channelPowered  (channelPowered)
    );

    char_host_model host
    (
        .clk    (clk),
        .charIn (charIn)
    );

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic wrap_up();
        if (errors == 0 && nTests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // ------------------------------------------------------------
    // Register bus master and reference models
    // ------------------------------------------------------------
    // Holds the request until pready is sampled high; the bound cuts a hang short.
    task automatic apbXfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        apbReq <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        apbReq.penable <= 1'h1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk);
            if (apbRsp.pready === 1'h1)
                break;
        end
        if (k == 20)
        begin
            errors++;
            wrap_up();
        end
        rd = apbRsp.prdata;
        er = apbRsp.pslverr;
        apbReq <= '0;
        // One idle edge keeps the next request from assigning apbReq in this same time step.
        @(posedge clk);
    endtask

    function automatic logic [3:0] pw(input logic [7:0] b);
        return {b[7] | b[6], b[5] | b[4], b[3] | b[2], b[1] | b[0]};
    endfunction

    task automatic resetModel();
        oeExp = 8'h00;
        bistExp = 8'hFF;
        oeOpen = 1'h0;
        bistOpen = 1'h0;
        bondNow = 2'h0;
        foreach (syncLeft[i]) syncLeft[i] = 0;
    endtask

    // Writes the control word, then checks the driver outputs and the status word.
    task automatic wctl(input logic [1:0] bd, input logic lp, oe, bl, input logic [7:0] bits);
        apbXfer(1'h1, CTRL_OFFSET, {16'h0000, bits, 3'h0, bl, oe, lp, bd});
        if (oe || oeOpen)
            oeExp = bits;
        if (bl || bistOpen)
            bistExp = bits;
        oeOpen = oe;
        bistOpen = bl;
        bondNow = bd;
        @(posedge clk);
        chk("driverEnable", 32'(driverEnable), 32'(oeExp));
        chk("serialDriverOne", 32'(serialDriverOne), lp ? 32'(oeExp) : 32'h0);
        chk("channelPowered", 32'(channelPowered), 32'(pw(oeExp)));
        apbXfer(1'h0, STATUS_OFFSET, 32'h0);
        chk("status", rd, {12'h000, pw(oeExp), bistExp, oeExp});
    endtask

    // Character type from the sampled control pairs, before sync and self-test state.
    function automatic char_type_t dec(input logic [3:0][1:0] c, input logic [1:0] bd, input int ch);
        logic [1:0] code;
        code = c[ch];
        if (bd == BOND_DUAL && c[(ch / 2) * 2 + 1][0])
            return CT_WSYNC;
        if (bd[1] && c[1][0])
            return CT_WSYNC;
        if (bd == BOND_DUAL && ch % 2 == 1)
            code = {c[ch][1], c[ch - 1][0]};
        if (bd[1])
            code = {c[ch][1], c[0][0]};
        return char_type_t'({1'h0, code});
    endfunction

    // Sends random character sets and notes the expected result of each.
    task automatic sendChars(input int n);
        logic [3:0][1:0] c;
        logic [3:0][7:0] b;
        char_out_t       e;
        char_type_t      t;
        repeat (n)
        begin
            c = 8'($urandom & $urandom);
            b = $urandom;
            e = '0;
            e.strobe = 1'h1;
            for (int ch = 0; ch < 4; ch++)
            begin
                t = dec(c, bondNow, ch);
                if (bistExp[2 * ch + 1] == 1'h0)
                begin
                    t = CT_BIST;
                    syncLeft[ch] = 0;
                end
                else if (syncLeft[ch] != 0)
                begin
                    t = CT_WSYNC;
                    e.syncIndex[ch] = 4'(16 - syncLeft[ch]);
                    syncLeft[ch]--;
                end
                else if (t == CT_WSYNC)
                    syncLeft[ch] = 15;
                e.charType[ch] = t;
                e.charByte[ch] = (t == CT_BIST) ? 8'h00 : b[ch];
            end
            expQ.push_back(e);
            host.send(c, b);
        end
        host.release_lines();
    endtask

    // Each strobe takes the oldest note; bytes matter only for data and self-test characters.
    always @(negedge clk)
    begin
        if (charOut.strobe === 1'h1)
        begin
            if (expQ.size() == 0)
                chk("strobe", 32'h1, 32'h0);
            else
            begin
                monE = expQ.pop_front();
                for (int ch = 0; ch < 4; ch++)
                begin
                    chk("charType", 32'(charOut.charType[ch]), 32'(monE.charType[ch]));
                    chk("syncIndex", 32'(charOut.syncIndex[ch]), 32'(monE.syncIndex[ch]));
                    if (monE.charType[ch] == CT_DATA || monE.charType[ch] == CT_BIST)
                        chk("charByte", 32'(charOut.charByte[ch]), 32'(monE.charByte[ch]));
                end
            end
        end
    end

    // Watchdog for the whole run.
    initial
    begin
        repeat (50000) @(posedge clk);
        errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        apbReq = '0;
        ce = 1'h1;
        rstn = 1'h0;
        errors = 0;
        nTests = 0;
        void'($urandom(32'h85A8871B));
        resetModel();
        repeat (3) @(posedge clk);
        chk("driverEnable", 32'(driverEnable), 32'h0);
        rstn <= 1'h1;
        apbXfer(1'h0, STATUS_OFFSET, 32'h0);
        chk("status", rd, 32'h0000FF00);
        apbXfer(1'h0, 12'h008, 32'h0);
        chk("pslverr", 32'(er), 32'h1);
        chk("prdata", rd, 32'h0);
        repeat (12) wctl(2'h0, 1'($urandom), 1'($urandom), 1'($urandom), 8'($urandom));
        // A low clock enable must hold back the answer to this write.
        fork
            wctl(2'h0, 1'h0, 1'h1, 1'h0, 8'h0C);
            begin
                ce <= 1'h0;
                repeat (3) @(posedge clk);
                chk("frozenReady", 32'(apbRsp.pready), 32'h0);
                ce <= 1'h1;
            end
        join
        wctl(2'h0, 1'h1, 1'h0, 1'h0, 8'hFF);
        wctl(2'h0, 1'h1, 1'h0, 1'h0, 8'h00);
        apbXfer(1'h0, CTRL_OFFSET, 32'h0);
        chk("ctrl", rd, 32'h00000004);
        // A second reset in mid-run must drop every driver.
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        chk("driverEnable", 32'(driverEnable), 32'h0);
        rstn <= 1'h1;
        resetModel();
        wctl(2'h0, 1'h0, 1'h1, 1'h1, 8'hFF);
        wctl(2'h0, 1'h0, 1'h0, 1'h0, 8'hFF);
        for (int bd = 0; bd < 4; bd++)
        begin
            wctl(2'(bd), 1'h0, 1'h0, 1'h0, 8'hFF);
            sendChars(64);
        end
        wctl(2'h0, 1'h0, 1'h0, 1'h1, 8'hF5);
        wctl(2'h0, 1'h0, 1'h0, 1'h0, 8'hF5);
        sendChars(24);
        repeat (4) @(posedge clk);
        chk("queueLeft", 32'(expQ.size()), 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
